// ==== design/tsat_serial.sv ====
// Purpose: Three-wire clocked serial interface, 8-bit units, with 16-byte auto transfer
// Assumes: APB3 register access; pin inputs synchronous to mclk; one clock domain
// Notes: Pins are split into out / active-low output enable / in
`timescale 1ns/1ns

module tsat_serial
    import tsat_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOeN,
    output logic soOut,
    output logic soOeN,
    input wire logic siIn,
    output logic transferDoneIrq
);

    tsat_state_t s;
    tsat_state_t n;

    function automatic logic [7:0] orderBits(input logic [7:0] d, input logic lsbFirst);
        logic [7:0] r;
        r = d;
        if (lsbFirst) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = d[7 - i];
            end
        end
        return r;
    endfunction : orderBits

    function automatic logic isMapped(input logic [15:0] idx);
        return (idx == IDX_MODE) || (idx == IDX_CTRL) || (idx == IDX_SHIFT)
            || (idx == IDX_INTV) || (idx == IDX_PTR)
            || ((idx >= IDX_RAM) && (idx <= IDX_RAM_LAST));
    endfunction : isMapped

    function automatic logic [6:0] gapHalves(input logic [7:0] intv);
        logic [6:0] g;
        g = GAP_HALVES_FREE;
        if (intv[INTV_EN_BIT]) begin
            if (intv[INTV_N_LSB +: 5] == 5'h00) begin
                g = GAP_HALVES_ZERO;
            end else begin
                g = {1'b0, intv[INTV_N_LSB +: 5], 1'b0} + GAP_HALVES_ADD;
            end
        end
        return g;
    endfunction : gapHalves

    logic enable;
    logic lsbFirst;
    logic autoMode;
    logic extClk;
    logic rxOn;
    logic [1:0] clkSel;
    logic [2:0] halfLast;
    logic tick;
    logic extFall;
    logic extRise;
    logic fallEv;
    logic riseEv;
    logic halfEv;
    logic access;
    logic [15:0] regIdx;
    logic [7:0] shifted;
    logic [3:0] ramIdx;

    assign enable = s.mode[MODE_EN_BIT];
    assign lsbFirst = s.mode[MODE_DIR_BIT];
    assign autoMode = s.mode[MODE_AUTO_BIT];
    assign clkSel = s.mode[MODE_CLK_LSB +: 2];
    assign extClk = (clkSel == CLK_EXTERNAL);
    assign rxOn = !autoMode || s.ctrl[CTRL_RX_BIT];
    assign regIdx = paddr[17:2];
    assign ramIdx = regIdx[3:0];
    assign access = psel && penable;

    // Half period of the internal serial clock is 2, 4 or 8 mclk
    assign halfLast = 3'((4'h1 << clkSel) - 4'h1);
    assign tick = (s.pre == halfLast);
    assign extFall = s.sckPrev && !sckIn;
    assign extRise = !s.sckPrev && sckIn;
    assign fallEv = extClk ? extFall : (tick && s.sckOut);
    assign riseEv = extClk ? extRise : (tick && !s.sckOut);
    assign halfEv = extClk ? (extFall || extRise) : tick;

    always_comb begin
        n = s;
        n.doneIrq = 1'b0;
        n.sckPrev = sckIn;
        n.pre = tick ? 3'h0 : 3'(s.pre + 3'h1);
        shifted = {s.shreg[6:0], rxOn ? siIn : 1'b0};

        unique case (s.phase)
            TSAT_IDLE: begin
                n.sckOut = 1'b1;
                // Data drops one mclk after the final rise, so the far side still latches it
                if (autoMode && !s.ctrl[CTRL_BUSY_BIT]) begin
                    n.soOut = 1'b0;
                end
            end
            TSAT_SHIFT: begin
                if (fallEv) begin
                    n.soOut = s.shreg[7];
                    if (!extClk) begin
                        n.sckOut = 1'b0;
                    end
                end else if (riseEv) begin
                    n.shreg = shifted;
                    n.bitCnt = 4'(s.bitCnt + 4'h1);
                    if (!extClk) begin
                        n.sckOut = 1'b1;
                    end
                    if (s.bitCnt == 4'h7) begin
                        n.bitCnt = 4'h0;
                        if (!autoMode) begin
                            n.phase = TSAT_IDLE;
                            n.doneIrq = 1'b1;
                        end else begin
                            if (s.ctrl[CTRL_RX_BIT]) begin
                                n.ram[s.ptr] = orderBits(shifted, lsbFirst);
                            end
                            n.gapCnt = gapHalves(s.intv);
                            if (s.ptr != 4'h0) begin
                                n.ptr = 4'(s.ptr - 4'h1);
                                n.phase = TSAT_GAP;
                            end else if (s.ctrl[CTRL_REPEAT_BIT]) begin
                                n.ptr = s.startPtr;
                                n.phase = TSAT_GAP;
                            end else begin
                                n.phase = TSAT_IDLE;
                                n.ctrl[CTRL_BUSY_BIT] = 1'b0;
                                n.doneIrq = 1'b1;
                            end
                        end
                    end
                end
            end
            TSAT_GAP: begin
                // With the internal clock, the clock rests high through the gap, so the next byte starts on a fall
                if (halfEv) begin
                    n.gapCnt = 7'(s.gapCnt - 7'h01);
                    if (s.gapCnt <= 7'h01) begin
                        n.shreg = orderBits(s.ram[s.ptr], lsbFirst);
                        n.bitCnt = 4'h0;
                        n.phase = TSAT_SHIFT;
                    end
                end
            end
        endcase

        // Leaving auto mode mid-run counts as a suspension
        if (!autoMode && s.phase == TSAT_GAP) begin
            n.phase = TSAT_IDLE;
        end
        if (!autoMode) begin
            n.ctrl[CTRL_BUSY_BIT] = 1'b0;
        end

        if (!enable) begin
            n.phase = TSAT_IDLE;
            n.bitCnt = 4'h0;
            n.sckOut = 1'b1;
            n.ctrl[CTRL_BUSY_BIT] = 1'b0;
        end

        // Pin drive: low enable means driving
        n.sckOeN = !((enable && !extClk) || (!enable && s.mode[MODE_IDLE_BIT]));
        n.soOeN = !enable;

        // APB: one wait state so read data and answer come from flops
        if (access && !s.pready) begin
            n.pready = 1'b1;
            n.pslverr = !isMapped(regIdx) || (paddr[1:0] != 2'h0);
            n.prdata = 32'h0000_0000;
            if (regIdx == IDX_MODE) begin
                n.prdata[7:0] = s.mode;
            end else if (regIdx == IDX_CTRL) begin
                n.prdata[7:0] = s.ctrl;
            end else if (regIdx == IDX_SHIFT) begin
                n.prdata[7:0] = orderBits(s.shreg, lsbFirst);
            end else if (regIdx == IDX_INTV) begin
                n.prdata[7:0] = s.intv;
            end else if (regIdx == IDX_PTR) begin
                n.prdata[3:0] = s.ptr;
            end else if (isMapped(regIdx)) begin
                n.prdata[7:0] = s.ram[ramIdx];
            end
        end else if (s.pready) begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
            if (access && pwrite && !s.pslverr) begin
                if (regIdx == IDX_MODE) begin
                    n.mode = pwdata[7:0] & MODE_WMASK;
                end else if (regIdx == IDX_CTRL) begin
                    n.ctrl = (pwdata[7:0] & CTRL_WMASK)
                        | (n.ctrl & ~CTRL_WMASK);
                end else if (regIdx == IDX_INTV) begin
                    n.intv = pwdata[7:0] & INTV_WMASK;
                end else if (regIdx == IDX_PTR) begin
                    n.ptr = pwdata[3:0];
                end else if (regIdx == IDX_SHIFT) begin
                    // Writes while disabled or busy are dropped, not queued
                    if (enable && s.phase == TSAT_IDLE && (!extClk || sckIn)) begin
                        n.bitCnt = 4'h0;
                        n.phase = TSAT_SHIFT;
                        if (autoMode) begin
                            n.ctrl[CTRL_BUSY_BIT] = 1'b1;
                            n.startPtr = s.ptr;
                            n.shreg = orderBits(s.ram[s.ptr], lsbFirst);
                        end else begin
                            n.shreg = orderBits(pwdata[7:0], lsbFirst);
                        end
                    end
                end else begin
                    n.ram[ramIdx] = pwdata[7:0];
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.mode <= RESET_VAL;
            s.ctrl <= RESET_VAL;
            s.intv <= RESET_VAL;
            s.phase <= TSAT_IDLE;
            s.sckOut <= 1'b1;
            // Matches the idle-high pin so no false edge follows reset
            s.sckPrev <= 1'b1;
            s.sckOeN <= 1'b1;
            s.soOeN <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign sckOut = s.sckOut;
    assign sckOeN = s.sckOeN;
    assign soOut = s.soOut;
    assign soOeN = s.soOeN;
    assign transferDoneIrq = s.doneIrq;

endmodule : tsat_serial

// ==== design/tsat_pkg.sv ====
// Purpose: Shared constants and types for the three-wire serial block with auto transfer
// Assumes: APB3 slave, 32-bit data, registers on word-aligned byte address = 4 * index
// Notes: Register indices are the printed offsets; byte address is four times the index
package tsat_pkg;

    localparam int APB_AW = 18;

    // Register indices (byte address = index * 4)
    localparam logic [15:0] IDX_MODE = 16'hff78;
    localparam logic [15:0] IDX_CTRL = 16'hff79;
    localparam logic [15:0] IDX_SHIFT = 16'hff7a;
    localparam logic [15:0] IDX_INTV = 16'hff7b;
    localparam logic [15:0] IDX_PTR = 16'hff7c;
    localparam logic [15:0] IDX_RAM = 16'hff80;
    localparam logic [15:0] IDX_RAM_LAST = 16'hff8f;

    // Mode register fields
    localparam int MODE_EN_BIT = 7;
    localparam int MODE_DIR_BIT = 6;
    localparam int MODE_AUTO_BIT = 5;
    localparam int MODE_IDLE_BIT = 4;
    localparam int MODE_CLK_LSB = 0;
    localparam logic [7:0] MODE_WMASK = 8'hf3;

    // Auto control register fields
    localparam int CTRL_RX_BIT = 7;
    localparam int CTRL_REPEAT_BIT = 6;
    localparam int CTRL_BUSY_BIT = 3;
    localparam logic [7:0] CTRL_WMASK = 8'hc0;

    // Interval register fields
    localparam int INTV_EN_BIT = 7;
    localparam int INTV_N_LSB = 0;
    localparam logic [7:0] INTV_WMASK = 8'h9f;

    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [1:0] CLK_EXTERNAL = 2'h0;

    // Byte gap in serial half periods: 2.5 periods for n = 0, (n + 1.5) periods else
    localparam logic [6:0] GAP_HALVES_ZERO = 7'h05;
    localparam logic [6:0] GAP_HALVES_ADD = 7'h03;
    // Gap when interval control is off: half a serial period
    localparam logic [6:0] GAP_HALVES_FREE = 7'h01;

    typedef enum logic [1:0] {
        TSAT_IDLE,
        TSAT_SHIFT,
        TSAT_GAP
    } tsat_phase_t;

    typedef struct packed {
        logic [15:0][7:0] ram;
        logic [7:0] mode;
        logic [7:0] ctrl;
        logic [7:0] intv;
        logic [7:0] shreg;
        logic [3:0] ptr;
        logic [3:0] startPtr;
        logic [3:0] bitCnt;
        logic [2:0] pre;
        logic [6:0] gapCnt;
        tsat_phase_t phase;
        logic sckPrev;
        logic sckOut;
        logic sckOeN;
        logic soOut;
        logic soOeN;
        logic doneIrq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tsat_state_t;

endpackage : tsat_pkg

// ==== dv/tsat_serial_asserts.sv ====
// Purpose: Port checks for the serial block
// Assumes: one clock, asynchronous active-high reset
// Notes: bound after the module
`timescale 1ns/1ns
module tsat_serial_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sckOut,
    input wire logic sckOeN,
    input wire logic soOut,
    input wire logic soOeN,
    input wire logic transferDoneIrq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [2:0] fallCnt;
    // Driven clock falls modulo one byte; bytes never end mid-count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) fallCnt <= 3'h0;
        else if (transferDoneIrq) fallCnt <= 3'h0;
        else if (!sckOeN && $fell(sckOut)) fallCnt <= fallCnt + 3'h1;
    end
    bus_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer late");
    bus_error_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    irq_pulse_a: assert property (transferDoneIrq |=> !transferDoneIrq)
        else $error("done pulse too long");
    irq_idle_a: assert property (transferDoneIrq && !sckOeN |-> sckOut)
        else $error("clock not idle high at done");
    off_pins_a: assert property (soOeN && $past(soOeN) |-> sckOut && !transferDoneIrq)
        else $error("activity while disabled");
    sck_half_a: assert property (!sckOeN && $changed(sckOut) |=> $stable(sckOut))
        else $error("serial half period too short");
    so_on_fall_a: assert property (!sckOeN && !soOeN && $changed(soOut) |-> $fell(sckOut) || !soOut)
        else $error("data changed off a falling edge");
    eight_bits_a: assert property (transferDoneIrq |-> fallCnt == 3'h0)
        else $error("done not on a byte boundary");
    cover property (transferDoneIrq);
    cover property (pslverr);
    cover property (!sckOeN && $fell(sckOut));
endmodule : tsat_serial_asserts

bind tsat_serial tsat_serial_asserts u_chk (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .sckOut(sckOut),
    .sckOeN(sckOeN), .soOut(soOut), .soOeN(soOeN), .transferDoneIrq(transferDoneIrq));

// ==== dv/tsat_peer.sv ====
// Purpose: External clocked serial peripheral on the far side
// Assumes: clock idles high, wire order MSB first
// Notes: makes its own clock only inside burst
`timescale 1ns/1ns
module tsat_peer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sckOut,
    input wire logic sckOeN,
    input wire logic soOut,
    input wire logic [7:0] txByte,
    output logic sckIn,
    output logic siIn,
    output logic [7:0] rxByte
);
    logic pclk = 1'b1;
    logic prev;
    logic [7:0] sh;
    logic [2:0] cnt;
    // Pin level: the device when it drives, else this peer
    assign sckIn = sckOeN ? pclk : sckOut;
    // Next bit on a fall, sample on a rise
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev <= 1'b1;
            cnt <= 3'h0;
            siIn <= 1'b0;
            rxByte <= 8'h00;
        end else begin
            prev <= sckIn;
            if (prev && !sckIn) begin
                siIn <= (cnt == 3'h0) ? txByte[7] : sh[7];
                sh <= (cnt == 3'h0) ? {txByte[6:0], 1'b0} : {sh[6:0], 1'b0};
                cnt <= cnt + 3'h1;
            end
            if (!prev && sckIn) rxByte <= {rxByte[6:0], soOut};
        end
    end
    task automatic burst(input int h);
        repeat (16) begin
            repeat (h) @(posedge mclk);
            pclk <= !pclk;
        end
    endtask : burst
endmodule : tsat_peer

// ==== dv/tsat_serial_test.sv ====
// Purpose: Self-checking bench for the serial block
// Assumes: one wait state per bus access
// Notes: expectations follow bit order and gap rules
`timescale 1ns/1ns
module tsat_serial_test;
    import tsat_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, sckIn, sckOut, sckOeN, soOut, soOeN, siIn, irq, err;
    logic [7:0] txByte = 8'h00;
    logic [7:0] rxByte, rd, d, p;
    logic [7:0] ram[16];
    logic [7:0] ivl[5] = '{8'h80, 8'h81, 8'h82, 8'h05, 8'h00};
    int errors = 0;
    int checks = 0;
    int seed = 32'hdbf871b8;
    int irqCnt = 0, lowCnt = 0, hiRun = 0, hiMax = 0, n, c0;
    int gaps[5];
    tsat_serial u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sckIn(sckIn), .sckOut(sckOut), .sckOeN(sckOeN), .soOut(soOut),
        .soOeN(soOeN), .siIn(siIn), .transferDoneIrq(irq));
    tsat_peer u_peer (.mclk(mclk), .rst(rst), .sckOut(sckOut), .sckOeN(sckOeN),
        .soOut(soOut), .txByte(txByte), .sckIn(sckIn), .siIn(siIn), .rxByte(rxByte));
    always #50 mclk = !mclk;
    // Counted mid-cycle so the main sequence never races them
    always @(negedge mclk) begin
        if (irq) irqCnt++;
        if (!sckOut) lowCnt++;
        if (sckOut) hiRun++;
        else begin
            if (hiRun > hiMax) hiMax = hiRun;
            hiRun = 0;
        end
    end
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction : rev
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            errors++;
            wrap_up();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(rd, e);
    endtask : rdc
    task automatic waitBusy(input int lim);
        int k;
        k = 0;
        do begin
            apb(1'b0, IDX_CTRL, 8'h00);
            k++;
        end while (rd[CTRL_BUSY_BIT] !== 1'b0 && k < lim);
        if (rd[CTRL_BUSY_BIT] !== 1'b0) begin
            errors++;
            wrap_up();
        end
    endtask : waitBusy
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rdc(IDX_MODE, RESET_VAL);
        rdc(IDX_CTRL, RESET_VAL);
        rdc(IDX_INTV, RESET_VAL);
        chk({soOeN, sckOeN}, 2'b11);
        apb(1'b1, IDX_CTRL, 8'hff);
        rdc(IDX_CTRL, CTRL_WMASK);
        apb(1'b1, IDX_INTV, 8'hff);
        rdc(IDX_INTV, INTV_WMASK);
        apb(1'b0, 16'hff70, 8'h00);
        chk(err, 1'b1);
        apb(1'b1, IDX_CTRL, 8'h00);
        apb(1'b1, IDX_MODE, 8'h10);
        repeat (2) @(negedge mclk);
        chk({sckOeN, sckOut}, 2'b01);
        apb(1'b1, IDX_SHIFT, 8'h5a);
        c0 = irqCnt;
        apb(1'b1, IDX_MODE, 8'h81);
        repeat (100) @(posedge mclk);
        chk(irqCnt, c0);
        $display("register test done");
        for (int s = 0; s < 4; s++) begin
            d = 8'($random(seed));
            p = 8'($random(seed));
            txByte <= p;
            apb(1'b1, IDX_MODE, {1'b1, s[0], 4'h0, s[1:0]});
            c0 = irqCnt;
            lowCnt = 0;
            apb(1'b1, IDX_SHIFT, d);
            // External clock at a 3 mclk half period, between the internal 2 and 4 mclk ones
            if (s == 0) u_peer.burst(3);
            for (int k = 0; k < 3000 && irqCnt == c0; k++) @(posedge mclk);
            // Far side latches the last bit one mclk after the final rise
            @(negedge mclk);
            chk(irqCnt, c0 + 1);
            chk(rxByte, s[0] ? rev(d) : d);
            rdc(IDX_SHIFT, s[0] ? rev(p) : p);
            if (s > 0) chk(lowCnt, 8 << s);
        end
        $display("plain test done");
        for (int i = 0; i < 5; i++) begin
            n = (i == 4) ? 16 : 2;
            p = 8'($random(seed));
            txByte <= p;
            for (int j = 0; j < n; j++) begin
                ram[j] = 8'($random(seed));
                apb(1'b1, IDX_RAM + j[15:0], ram[j]);
            end
            apb(1'b1, IDX_PTR, n[7:0] - 8'h01);
            apb(1'b1, IDX_CTRL, {i != 2, 7'h00});
            apb(1'b1, IDX_INTV, ivl[i]);
            apb(1'b1, IDX_MODE, 8'ha1);
            c0 = irqCnt;
            hiMax = 0;
            // Negative start keeps the idle stretch before the first fall out of the gap figure
            hiRun = -1000;
            apb(1'b1, IDX_SHIFT, 8'h00);
            rdc(IDX_CTRL, {i != 2, 7'h08});
            waitBusy(400);
            repeat (4) @(posedge mclk);
            chk(irqCnt, c0 + 1);
            chk(soOut, 1'b0);
            chk(rxByte, ram[0]);
            for (int j = 0; j < n; j++) rdc(IDX_RAM + j[15:0], (i != 2) ? p : ram[j]);
            gaps[i] = hiMax;
        end
        chk(gaps[1], gaps[0]);
        chk(gaps[2], gaps[0] + 4);
        chk(gaps[4], gaps[3]);
        $display("auto test done");
        apb(1'b1, IDX_PTR, 8'h01);
        apb(1'b1, IDX_CTRL, 8'hc0);
        apb(1'b1, IDX_SHIFT, 8'h00);
        repeat (300) @(posedge mclk);
        rdc(IDX_CTRL, 8'hc8);
        apb(1'b1, IDX_MODE, 8'h81);
        rdc(IDX_CTRL, 8'hc0);
        $display("repeat test done");
        wrap_up();
    end
endmodule : tsat_serial_test
